// ==== lmp_regs.vh ====
// register offsets, field positions, reset values and fixed link constants
`ifndef LMP_REGS_VH
`define LMP_REGS_VH

// register byte offsets
`define LMP_OFF_MODE_CTRL   8'h00
`define LMP_OFF_MULTIFRAME  8'h04
`define LMP_OFF_LANE_SEL    8'h08
`define LMP_OFF_PARAM0      8'h0C
`define LMP_OFF_PARAM1      8'h10
`define LMP_OFF_ILAS0       8'h14
`define LMP_OFF_ILAS1       8'h18
`define LMP_OFF_ILAS2       8'h1C
`define LMP_OFF_ILAS3       8'h20

// mode control fields
`define LMP_MODE_LSB        0
`define LMP_MODE_MSB        4
`define LMP_SCR_BIT         8
`define LMP_DID_LSB         16
`define LMP_DID_MSB         23

// reset values
`define LMP_RST_MODE        5'h00
`define LMP_RST_FRAMES_M1   8'h1F
`define LMP_RST_DID         8'h00
`define LMP_RST_SCR         1'b0
`define LMP_RST_LANE        3'h0

// fixed link parameter values
`define LMP_JESDV           3'h1
`define LMP_SUBCLASSV       3'h1
`define LMP_ILAS_ZERO       8'h00
`define LMP_EXT_MB          2'h1
`define LMP_K64_SCALE       16'h0100

// htrans encodings
`define LMP_HTRANS_NONSEQ   2'h2

`endif

// ==== lmp_mode_table.v ====
// mode code to transport parameter decoder
`timescale 1ns/1ps
`include "lmp_regs.vh"
module lmp_mode_table (
    // mode selection
    input  wire [4:0] mode,
    // derived transport parameters
    output reg        mode_valid,
    output reg        enc_64b66b,
    output reg  [3:0] lanes,
    output reg  [3:0] converters,
    output reg  [3:0] octets,
    output reg  [3:0] samples,
    output reg  [3:0] resolution,
    output reg  [3:0] sample_bits,
    output reg        high_density,
    output reg  [1:0] ext_mb,
    output reg  [8:0] ratio_x16
);
    // packed row: valid, enc, l, m, f, s, n, n', hd, r*16
    reg [35:0] row;

    // one row per supported mode, all others flag invalid
    always @* begin
        case (mode)
            5'h00: row = {2'b10, 4'h8, 4'h8, 4'h8, 4'h5, 4'h9, 4'hC, 1'b0, 9'h080};
            5'h01: row = {2'b10, 4'h6, 4'h4, 4'h2, 4'h2, 4'h9, 4'hC, 1'b1, 9'h0A0};
            5'h02: row = {2'b10, 4'h4, 4'h4, 4'h1, 4'h1, 4'h8, 4'h8, 1'b0, 9'h0A0};
            5'h03: row = {2'b10, 4'h4, 4'h4, 4'h5, 4'h4, 4'h9, 4'hA, 1'b0, 9'h0C8};
            5'h04: row = {2'b11, 4'h3, 4'h4, 4'h2, 4'h1, 4'h9, 4'hC, 1'b1, 9'h108};
            5'h05: row = {2'b11, 4'h2, 4'h4, 4'h2, 4'h1, 4'h8, 4'h8, 1'b0, 9'h108};
            5'h06: row = {2'b11, 4'h6, 4'h4, 4'h2, 4'h2, 4'h9, 4'hC, 1'b1, 9'h084};
            5'h07: row = {2'b11, 4'h4, 4'h4, 4'h1, 4'h1, 4'h8, 4'h8, 1'b0, 9'h084};
            5'h08: row = {2'b11, 4'h4, 4'h4, 4'h3, 4'h2, 4'h9, 4'hC, 1'b0, 9'h0C6};
            5'h09: row = {2'b10, 4'h8, 4'h4, 4'h1, 4'h2, 4'h8, 4'h8, 1'b0, 9'h050};
            5'h0A: row = {2'b10, 4'h8, 4'h8, 4'h5, 4'h4, 4'h9, 4'hA, 1'b0, 9'h064};
            5'h0E: row = {2'b11, 4'h8, 4'h8, 4'h3, 4'h2, 4'h9, 4'hC, 1'b0, 9'h063};
            default: row = 36'h0_0000_0000;  // unsupported code
        endcase
    end

    // unpack the row into named outputs
    always @* begin
        mode_valid   = row[35];
        enc_64b66b   = row[34];
        lanes        = row[33:30];
        converters   = row[29:26];                // (R13)
        octets       = row[25:22];
        samples      = row[21:18];
        resolution   = row[17:14];
        sample_bits  = row[13:10];                // (R14)
        high_density = row[9];
        ratio_x16    = row[8:0];                  // (R2)
        ext_mb       = row[34] ? `LMP_EXT_MB : 2'h0;  // (R4)
    end
endmodule // lmp_mode_table

// ==== lmp_ilas_builder.v ====
// alignment parameter set octets and checksum for one lane
`timescale 1ns/1ps
`include "lmp_regs.vh"
module lmp_ilas_builder (
    // user settings
    input  wire [7:0]   device_id,
    input  wire         scrambler_on,
    input  wire [2:0]   lane_id,
    // derived parameters, natural values; frames as frames minus one
    input  wire [3:0]   lanes,
    input  wire [3:0]   octets,
    input  wire [7:0]   frames_m1,
    input  wire [3:0]   converters,
    input  wire [3:0]   resolution,
    input  wire [3:0]   sample_bits,
    input  wire [3:0]   samples,
    // octets 0..13, octet 0 in the low byte
    output reg  [111:0] octet_bus,
    output reg  [7:0]   checksum
);
    // value minus one, as the link encodes counts
    function [4:0] m1;
        input [3:0] v;
        begin
            m1 = {1'b0, v} - 5'h01;
        end
    endfunction

    // field sum; adjust, bank, cf, hd, cs and reserved add zero
    always @* begin
        checksum = device_id + {5'h00, lane_id} + {7'h00, scrambler_on}  // (R10)
                 + {3'h0, m1(lanes)} + {3'h0, m1(octets)} + frames_m1
                 + {3'h0, m1(converters)} + {3'h0, m1(resolution)}
                 + {5'h00, `LMP_SUBCLASSV} + {3'h0, m1(sample_bits)}
                 + {5'h00, `LMP_JESDV} + {3'h0, m1(samples)};
    end

    // octet layout of the parameter set
    always @* begin
        octet_bus[7:0]     = device_id;                          // (R8)
        octet_bus[15:8]    = `LMP_ILAS_ZERO;                     // (R6)
        octet_bus[23:16]   = {3'h0, 2'h0, lane_id};              // (R9)
        octet_bus[31:24]   = {scrambler_on, 2'h0, m1(lanes)};    // (R8)
        octet_bus[39:32]   = {3'h0, m1(octets)};
        octet_bus[47:40]   = frames_m1;
        octet_bus[55:48]   = {3'h0, m1(converters)};
        octet_bus[63:56]   = {3'h0, m1(resolution)};             // (R7)
        octet_bus[71:64]   = {`LMP_SUBCLASSV, m1(sample_bits)};  // (R6)
        octet_bus[79:72]   = {`LMP_JESDV, m1(samples)};          // (R6)
        octet_bus[87:80]   = `LMP_ILAS_ZERO;                     // (R6)
        octet_bus[95:88]   = `LMP_ILAS_ZERO;
        octet_bus[103:96]  = `LMP_ILAS_ZERO;
        octet_bus[111:104] = checksum;                           // (R10)
    end
endmodule // lmp_ilas_builder

// ==== lmp_link_mode_set.v ====
// link mode parameter set: ahb-lite registers, mode decode, alignment set
//
// Contract
// (R1) one mode code derives all transport parameters
// (R2) lane ratio R sets line rate, pll
// (R3) frames setting used only in 8b/10b
// (R4) extended multiblock fixed at one, 64b/66b
// (R5) alignment set sent only in 8b/10b
// (R6) fixed alignment fields zero, versions one
// (R7) control bits reported zero in set
// (R8) device id and scrambler from user
// (R9) distinct lane id per lane
// (R10) checksum is field sum modulo 256
// (R11) host programs only supported mode codes
// (R12) host keeps frames within mode range
// (R13) converter count governs lane packing
// (R14) sample width is n plus tail
// (R15) 64b/66b frames equal 256*e/f
`timescale 1ns/1ps
`include "lmp_regs.vh"
module lmp_link_mode_set (
    // clock, reset, enable
    input  wire        clock,
    input  wire        reset,
    input  wire        clock_enable,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // derived link parameters
    output reg         mode_valid,
    output reg         enc_64b66b,
    output reg         ilas_enable,
    output reg  [3:0]  lane_count,
    output reg  [3:0]  converter_count,
    output reg  [3:0]  octets_per_frame,
    output reg  [3:0]  samples_per_frame,
    output reg  [3:0]  sample_resolution,
    output reg  [3:0]  bits_per_sample,
    output reg  [8:0]  serdes_ratio_x16,
    output reg  [8:0]  frames_per_multiframe,
    output reg  [1:0]  multiblocks_per_emb,
    output reg  [7:0]  ilas_checksum
);
    // user registers
    reg  [4:0]   link_mode_select;               // mode code
    reg  [7:0]   frames_per_multiframe_setting;  // frames minus one
    reg  [7:0]   link_device_identifier;         // device id
    reg          scrambler_enable_setting;       // scrambler on
    reg  [2:0]   lane_select;                    // lane shown in set
    // pending write from the address phase
    reg          wr_pend;
    reg  [7:0]   wr_addr;
    // next values, a pending write already applied
    reg  [4:0]   next_mode;
    reg  [7:0]   next_frames;
    reg  [7:0]   next_did;
    reg          next_scr;
    reg  [2:0]   next_lane;
    reg  [31:0]  next_rdata;
    // decoded parameters from the next mode code
    wire         dec_valid;
    wire         dec_enc64;
    wire [3:0]   dec_l;
    wire [3:0]   dec_m;
    wire [3:0]   dec_f;
    wire [3:0]   dec_s;
    wire [3:0]   dec_n;
    wire [3:0]   dec_np;
    wire         dec_hd;
    wire [1:0]   dec_e;
    wire [8:0]   dec_r;
    // effective frames per multiframe
    reg  [15:0]  k_64;
    reg  [8:0]   k_eff;
    // alignment set of the selected lane
    wire [111:0] ilas_octets;
    wire [7:0]   ilas_sum;
    // bus address phase accepted
    wire         addr_ok;

    assign addr_ok = hsel & hready & (htrans == `LMP_HTRANS_NONSEQ);

    // mode code decode, fed by next values so reads see fresh data
    lmp_mode_table u_table (
        .mode         (next_mode),
        .mode_valid   (dec_valid),
        .enc_64b66b   (dec_enc64),
        .lanes        (dec_l),
        .converters   (dec_m),
        .octets       (dec_f),
        .samples      (dec_s),
        .resolution   (dec_n),
        .sample_bits  (dec_np),
        .high_density (dec_hd),
        .ext_mb       (dec_e),
        .ratio_x16    (dec_r)
    ); // (R1)

    // alignment parameter set for the selected lane
    lmp_ilas_builder u_ilas (
        .device_id    (next_did),
        .scrambler_on (next_scr),
        .lane_id      (next_lane),
        .lanes        (dec_l),
        .octets       (dec_f),
        .frames_m1    (next_frames),
        .converters   (dec_m),
        .resolution   (dec_n),
        .sample_bits  (dec_np),
        .samples      (dec_s),
        .octet_bus    (ilas_octets),
        .checksum     (ilas_sum)
    );

    // register write merge: data phase of a pending write
    always @* begin
        next_mode   = link_mode_select;
        next_frames = frames_per_multiframe_setting;
        next_did    = link_device_identifier;
        next_scr    = scrambler_enable_setting;
        next_lane   = lane_select;
        if (wr_pend) begin
            case (wr_addr)
                `LMP_OFF_MODE_CTRL: begin
                    next_mode = hwdata[`LMP_MODE_MSB:`LMP_MODE_LSB];  // (R1)
                    next_scr  = hwdata[`LMP_SCR_BIT];                 // (R8)
                    next_did  = hwdata[`LMP_DID_MSB:`LMP_DID_LSB];    // (R8)
                end
                `LMP_OFF_MULTIFRAME: begin
                    next_frames = hwdata[7:0];
                end
                `LMP_OFF_LANE_SEL: begin
                    next_lane = hwdata[2:0];
                end
                default: begin
                    next_lane = lane_select;  // read-only or unmapped
                end
            endcase
        end
    end

    // frames per multiframe: fixed 256*e/f in 64b/66b, user value otherwise
    always @* begin
        k_64 = 16'h0000;
        if (dec_f != 4'h0) begin
            k_64 = (`LMP_K64_SCALE * {14'h0000, dec_e}) / {12'h000, dec_f};  // (R15)
        end
        if (dec_enc64) begin
            k_eff = k_64[8:0];                          // (R15)
        end else begin
            k_eff = {1'b0, next_frames} + 9'h001;       // (R3)
        end
    end

    // read data mux on the address-phase offset
    always @* begin
        case (haddr[7:0])
            `LMP_OFF_MODE_CTRL:
                next_rdata = {8'h00, next_did, 7'h00, next_scr, 3'h0, next_mode};
            `LMP_OFF_MULTIFRAME:
                next_rdata = {24'h00_0000, next_frames};
            `LMP_OFF_LANE_SEL:
                next_rdata = {29'h0000_0000, next_lane};
            `LMP_OFF_PARAM0:
                next_rdata = {dec_valid, 3'h0, dec_e, dec_hd, dec_enc64, dec_np,
                              dec_n, dec_s, dec_f, dec_m, dec_l};
            `LMP_OFF_PARAM1:
                next_rdata = {7'h00, k_eff, 7'h00, dec_r};
            `LMP_OFF_ILAS0:
                next_rdata = ilas_octets[31:0];
            `LMP_OFF_ILAS1:
                next_rdata = ilas_octets[63:32];
            `LMP_OFF_ILAS2:
                next_rdata = ilas_octets[95:64];
            `LMP_OFF_ILAS3:
                next_rdata = {16'h0000, ilas_octets[111:96]};
            default:
                next_rdata = 32'h0000_0000;  // unmapped reads zero
        endcase
    end

    // bus slave: zero wait states, always okay
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clock_enable) begin
            wr_pend <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= next_rdata;  // stands through the data phase
            end
        end
    end

    // user register storage
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            link_mode_select              <= `LMP_RST_MODE;
            frames_per_multiframe_setting <= `LMP_RST_FRAMES_M1;
            link_device_identifier        <= `LMP_RST_DID;
            scrambler_enable_setting      <= `LMP_RST_SCR;
            lane_select                   <= `LMP_RST_LANE;
        end else if (clock_enable) begin
            link_mode_select              <= next_mode;
            frames_per_multiframe_setting <= next_frames;
            link_device_identifier        <= next_did;
            scrambler_enable_setting      <= next_scr;
            lane_select                   <= next_lane;
        end
    end

    // derived parameter outputs, registered with the settings
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_valid            <= 1'b0;
            enc_64b66b            <= 1'b0;
            ilas_enable           <= 1'b0;
            lane_count            <= 4'h0;
            converter_count       <= 4'h0;
            octets_per_frame      <= 4'h0;
            samples_per_frame     <= 4'h0;
            sample_resolution     <= 4'h0;
            bits_per_sample       <= 4'h0;
            serdes_ratio_x16      <= 9'h000;
            frames_per_multiframe <= 9'h000;
            multiblocks_per_emb   <= 2'h0;
            ilas_checksum         <= 8'h00;
        end else if (clock_enable) begin
            mode_valid            <= dec_valid;
            enc_64b66b            <= dec_enc64;
            ilas_enable           <= dec_valid & ~dec_enc64;  // (R5)
            lane_count            <= dec_l;
            converter_count       <= dec_m;                  // (R13)
            octets_per_frame      <= dec_f;
            samples_per_frame     <= dec_s;
            sample_resolution     <= dec_n;
            bits_per_sample       <= dec_np;                 // (R14)
            serdes_ratio_x16      <= dec_r;                  // (R2)
            frames_per_multiframe <= k_eff;                  // (R3)
            multiblocks_per_emb   <= dec_e;                  // (R4)
            ilas_checksum         <= ilas_sum;               // (R10)
        end
    end
endmodule // lmp_link_mode_set

// ==== lmp_ilas_receiver.sv ====
// far-end receiver model that checks the alignment set checksum
`timescale 1ns/1ps
module lmp_ilas_receiver (
    // alignment set words, octet 0 in the low byte
    input  wire [31:0] word0,
    input  wire [31:0] word1,
    input  wire [31:0] word2,
    input  wire [31:0] word3,
    // checksum agrees with the received fields
    output reg         checksum_ok
);
    reg [7:0] sum; // running field sum, wraps at 256
    // add field values, not whole octets
    always @* begin
        sum = word0[7:0] + word0[20:16] + word0[31] + word0[28:24]
            + word1[7:0] + word1[15:8] + word1[23:16] + word1[28:24]
            + word2[7:5] + word2[4:0] + word2[15:13] + word2[12:8];
        checksum_ok = (sum == word3[15:8]);
    end
endmodule // lmp_ilas_receiver

// ==== lmp_link_mode_set_assertions.sv ====
// checker of bus response and derived link parameter outputs
`timescale 1ns/1ps
module lmp_link_mode_set_checker (
    // clock, reset and enable
    input wire       clock,
    input wire       reset,
    input wire       clock_enable,
    // bus request and response
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hwrite,
    input wire       hready,
    input wire       hreadyout,
    input wire       hresp,
    // derived parameters
    input wire       mode_valid,
    input wire       enc_64b66b,
    input wire       ilas_enable,
    input wire [3:0] lane_count,
    input wire [3:0] converter_count,
    input wire [3:0] octets_per_frame,
    input wire [3:0] samples_per_frame,
    input wire [3:0] sample_resolution,
    input wire [3:0] bits_per_sample,
    input wire [8:0] serdes_ratio_x16,
    input wire [8:0] frames_per_multiframe,
    input wire [1:0] multiblocks_per_emb
);
    reg         wr_ph; // a write data phase is under way
    wire [45:0] pars = {mode_valid, enc_64b66b, lane_count, converter_count,
                        octets_per_frame, samples_per_frame, sample_resolution,
                        bits_per_sample, multiblocks_per_emb, serdes_ratio_x16,
                        frames_per_multiframe}; // parameter outputs other than ilas_enable and ilas_checksum
    // track accepted write address phases
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ph <= 1'b0;
        end else if (clock_enable) begin
            wr_ph <= hsel && hready && htrans == 2'h2 && hwrite;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    AST_E_FIXED_64: assert property (enc_64b66b |-> multiblocks_per_emb == 2'h1)
        else $error("extended multiblock count not one");
    AST_E_IGNORED_8: assert property (!enc_64b66b |-> multiblocks_per_emb == 2'h0)
        else $error("multiblock count set in 8b10b");
    AST_ILAS_ONLY_8B: assert property (ilas_enable == (mode_valid && !enc_64b66b))
        else $error("alignment set enable wrong");
    AST_K_FIXED_64: assert property (enc_64b66b && octets_per_frame < 4'h3
        |-> ({4'h0, frames_per_multiframe} * {9'h000, octets_per_frame}) == 13'h0100)
        else $error("64b66b frames per multiframe wrong");
    AST_K_NONZERO_8B: assert property (mode_valid && !enc_64b66b
        |-> frames_per_multiframe != 9'h000)
        else $error("frames per multiframe zero");
    AST_INVALID_ZERO: assert property (!mode_valid |-> pars[43:9] == 35'h0)
        else $error("invalid mode has parameters");
    AST_WIDTH: assert property (mode_valid
        |-> bits_per_sample >= sample_resolution && sample_resolution >= 4'h8)
        else $error("sample width below resolution");
    AST_RATIO: assert property (mode_valid == (serdes_ratio_x16 != 9'h000))
        else $error("lane ratio missing");
    AST_PARAM_HOLD: assert property (!$stable(pars) && !$past(reset, 2) |-> $past(wr_ph))
        else $error("parameters changed unwritten");
    COV_64B: cover property (mode_valid && enc_64b66b);
    COV_8B: cover property (ilas_enable);
    COV_BAD: cover property (!mode_valid);
endmodule // lmp_link_mode_set_checker

bind lmp_link_mode_set lmp_link_mode_set_checker u_chk (
    .clock(clock), .reset(reset), .clock_enable(clock_enable), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .mode_valid(mode_valid), .enc_64b66b(enc_64b66b),
    .ilas_enable(ilas_enable), .lane_count(lane_count),
    .converter_count(converter_count), .octets_per_frame(octets_per_frame),
    .samples_per_frame(samples_per_frame), .sample_resolution(sample_resolution),
    .bits_per_sample(bits_per_sample), .serdes_ratio_x16(serdes_ratio_x16),
    .frames_per_multiframe(frames_per_multiframe),
    .multiblocks_per_emb(multiblocks_per_emb));

// ==== link_mode_parameter_set_test.sv ====
// self-checking testbench for the link mode parameter set
`timescale 1ns/1ps
module link_mode_parameter_set_test;
    reg         clock = 1'b0;  // 40 MHz
    reg         reset = 1'b1;  // async, active high
    reg         clock_enable = 1'b1;
    reg  [31:0] haddr = 32'h0000_0000;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0000_0000;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, mode_valid, enc_64b66b, ilas_enable;
    wire [3:0]  lane_count, converter_count, octets_per_frame;
    wire [3:0]  samples_per_frame, sample_resolution, bits_per_sample;
    wire [8:0]  serdes_ratio_x16, frames_per_multiframe;
    wire [1:0]  multiblocks_per_emb;
    wire [7:0]  ilas_checksum;
    wire        checksum_ok;   // receiver model verdict
    reg  [31:0] il0, il1, il2, il3; // alignment set words read back
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     cycles = 0;
    wire [36:0] par_now = {mode_valid, enc_64b66b, lane_count, converter_count,
                           octets_per_frame, samples_per_frame, sample_resolution,
                           bits_per_sample, multiblocks_per_emb, serdes_ratio_x16};

    always #12.5 clock = ~clock;

    lmp_link_mode_set dut (
        .clock(clock), .reset(reset), .clock_enable(clock_enable), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mode_valid(mode_valid),
        .enc_64b66b(enc_64b66b), .ilas_enable(ilas_enable),
        .lane_count(lane_count), .converter_count(converter_count),
        .octets_per_frame(octets_per_frame), .samples_per_frame(samples_per_frame),
        .sample_resolution(sample_resolution), .bits_per_sample(bits_per_sample),
        .serdes_ratio_x16(serdes_ratio_x16),
        .frames_per_multiframe(frames_per_multiframe),
        .multiblocks_per_emb(multiblocks_per_emb), .ilas_checksum(ilas_checksum));

    lmp_ilas_receiver rx (.word0(il0), .word1(il1), .word2(il2), .word3(il3),
        .checksum_ok(checksum_ok));

    // expected {valid, enc, L, M, F, S, N, N', E, R*16} per mode code
    function [36:0] exp_par(input reg [4:0] m);
        case (m)
            5'h00: exp_par = {2'b10, 24'h888_59C, 2'h0, 9'h080};
            5'h01: exp_par = {2'b10, 24'h642_29C, 2'h0, 9'h0A0};
            5'h02: exp_par = {2'b10, 24'h441_188, 2'h0, 9'h0A0};
            5'h03: exp_par = {2'b10, 24'h445_49A, 2'h0, 9'h0C8};
            5'h04: exp_par = {2'b11, 24'h342_19C, 2'h1, 9'h108};
            5'h05: exp_par = {2'b11, 24'h242_188, 2'h1, 9'h108};
            5'h06: exp_par = {2'b11, 24'h642_29C, 2'h1, 9'h084};
            5'h07: exp_par = {2'b11, 24'h441_188, 2'h1, 9'h084};
            5'h08: exp_par = {2'b11, 24'h443_29C, 2'h1, 9'h0C6};
            5'h09: exp_par = {2'b10, 24'h841_288, 2'h0, 9'h050};
            5'h0A: exp_par = {2'b10, 24'h885_49A, 2'h0, 9'h064};
            5'h0E: exp_par = {2'b11, 24'h883_29C, 2'h1, 9'h063};
            default: exp_par = 37'h0_0000_0000; // unsupported code
        endcase
    endfunction

    // compare one bus word or narrow output
    task chk_word(input string n, input reg [31:0] e, input reg [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("mismatch %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    // compare the parameter outputs other than frames per multiframe, ilas enable and checksum
    task chk_par(input string n, input reg [36:0] e, input reg [36:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("mismatch %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    // one single ahb-lite transfer, waits on hready in both phases
    task ahb(input reg wr, input reg [7:0] a, input reg [31:0] wd, output reg [31:0] rd);
        begin
            @(posedge clock);
            haddr <= {24'h00_0000, a};
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge clock);
            while (hreadyout !== 1'b1) @(posedge clock);
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge clock);
            while (hreadyout !== 1'b1) @(posedge clock);
            rd = hrdata;
        end
    endtask

    // write then let the parameter outputs settle
    task wr(input reg [7:0] a, input reg [31:0] d);
        reg [31:0] t;
        begin
            ahb(1'b1, a, d, t);
            @(negedge clock);
        end
    endtask

    // reset values, read-only and unmapped places
    task t_defaults;
        reg [31:0] v;
        begin
            ahb(1'b0, 8'h00, 32'h0, v); chk_word("mode_ctrl", 32'h0000_0000, v);
            ahb(1'b0, 8'h04, 32'h0, v); chk_word("multiframe", 32'h0000_001F, v);
            ahb(1'b0, 8'h0C, 32'h0, v); chk_word("param0", 32'h80C9_5888, v);
            ahb(1'b0, 8'h10, 32'h0, v); chk_word("param1", 32'h0020_0080, v);
            wr(8'h0C, 32'hFFFF_FFFF);
            ahb(1'b0, 8'h0C, 32'h0, v); chk_word("param0 ro", 32'h80C9_5888, v);
            ahb(1'b0, 8'h40, 32'h0, v); chk_word("unmapped", 32'h0000_0000, v);
        end
    endtask

    // every mode code, plus unsupported ones
    task t_modes;
        integer i;
        reg [4:0] m;
        begin
            for (i = 0; i < 17; i = i + 1) begin
                m = (i == 16) ? 5'h1F : i[4:0];
                wr(8'h00, {27'h000_0000, m});
                chk_par("mode params", exp_par(m), par_now);
            end
        end
    endtask

    // frames setting used in 8b/10b only
    task t_frames;
        reg [31:0] v;
        begin
            wr(8'h00, 32'h0000_0000);
            wr(8'h04, 32'h0000_003F); chk_word("k 8b10b", 32'd64, frames_per_multiframe);
            wr(8'h04, 32'h0000_00FF); chk_word("k max", 32'd256, frames_per_multiframe);
            wr(8'h00, 32'h0000_0004); chk_word("k 64b66b", 32'd128, frames_per_multiframe);
            wr(8'h04, 32'h0000_0003); chk_word("k ignored", 32'd128, frames_per_multiframe);
            chk_word("no align set", 32'd0, ilas_enable);
            @(posedge clock) clock_enable <= 1'b0;
            wr(8'h00, 32'h0);
            @(posedge clock) clock_enable <= 1'b1;
            chk_word("k frozen", 32'd128, frames_per_multiframe);
            wr(8'h00, 32'h0000_0007);
            ahb(1'b0, 8'h10, 32'h0, v); chk_word("param1 k", 32'h0100_0084, v);
            wr(8'h04, 32'h0000_001F);
        end
    endtask

    // alignment set fields, lane id and wrapping checksum
    task t_ilas;
        begin
            wr(8'h00, 32'h00F0_0102);
            wr(8'h08, 32'h0000_0003);
            chk_word("align set on", 32'd1, ilas_enable);
            ahb(1'b0, 8'h14, 32'h0, il0); chk_word("ilas0", 32'h8303_00F0, il0);
            ahb(1'b0, 8'h18, 32'h0, il1); chk_word("ilas1", 32'h0703_1F00, il1);
            ahb(1'b0, 8'h1C, 32'h0, il2); chk_word("ilas2", 32'h0000_2027, il2);
            ahb(1'b0, 8'h20, 32'h0, il3); chk_word("ilas3", 32'h0000_2900, il3);
            chk_word("checksum", 32'h0000_0029, ilas_checksum);
            wr(8'h08, 32'h0000_0005);
            chk_word("rx checksum", 32'd1, checksum_ok);
            ahb(1'b0, 8'h14, 32'h0, il0); chk_word("ilas0 lane5", 32'h8305_00F0, il0);
            chk_word("checksum lane5", 32'h0000_002B, ilas_checksum);
        end
    endtask

    // verdict and end of run
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask

    // cut a hang short
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            end_of_test;
        end
    end

    // main sequence; stimulus keeps frames in range, and t_modes also writes unsupported codes
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        t_defaults;
        t_modes;
        t_frames;
        t_ilas;
        end_of_test;
    end
endmodule // link_mode_parameter_set_test
